// ---- rtl/xmii_mac_if.sv ----
// MAC-side xMII data interface: MII, RMII and RGMII
`timescale 1ns/100ps
module xmii_mac_if
    import xmii_pkg::*;
#(
    parameter int DEPTH = ELAST_DEPTH
) (
    // Core clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // Configuration straps
    input  wire logic [1:0]       mode_sel,
    input  wire logic             rmii_master,
    input  wire logic [2:0]       fifo_thr,
    input  wire logic             full_duplex,
    input  wire logic             link_up,
    // Link clock: MII/RGMII 25 MHz, RMII 50 MHz reference
    input  wire logic             link_clk,
    // Recovered line side (core clock domain)
    input  wire logic             line_rx_valid,
    input  wire logic             line_rx_err,
    input  wire logic             line_false_carrier,
    input  wire logic [NIB_W-1:0] line_rx_nib,
    // MAC transmit pins
    input  wire logic [NIB_W-1:0] tx_d,
    input  wire logic             tx_en,
    input  wire logic             tx_er,
    // MAC receive pins
    output logic      [NIB_W-1:0] rx_d,
    output logic      [NIB_W-1:0] rx_d_fall,
    output logic                  rx_dv,
    output logic                  rx_er,
    output logic                  crs_dv,
    output logic                  rx_ctrl_rise,
    output logic                  rx_ctrl_fall,
    output logic                  ref_out,
    output logic                  ref_out_oe,
    // Core-side transmit stream
    output logic      [NIB_W-1:0] core_tx_nib,
    output logic                  core_tx_valid,
    output logic                  core_tx_err
);
    // ------------------------------------------------------------
    // Mode decode and strap capture
    // ------------------------------------------------------------
    xmii_mode_e mode_reg;
    logic       master_reg;
    logic [2:0] thr_reg;
    logic       link_rst;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_reg   <= MODE_MII;
            master_reg <= 1'b0;
            thr_reg    <= THR_MIN;
        end else begin
            mode_reg   <= xmii_mode_e'(mode_sel);
            master_reg <= rmii_master;
            thr_reg    <= (fifo_thr < THR_MIN) ? THR_MIN :
                          (fifo_thr > THR_MAX) ? THR_MAX : fifo_thr;
        end
    end

    // Reset into link domain
    xmii_sync #(.W(1)) u_rst_sync (
        .clk (link_clk),
        .d   (rst),
        .q   (link_rst)
    );

    // Mode into link domain
    logic [1:0] lmode;
    logic       lmaster;
    logic [2:0] lthr;
    logic [1:0] ldup_link;
    xmii_sync #(.W(6)) u_cfg_sync (
        .clk (link_clk),
        .d   ({mode_reg, master_reg, thr_reg}),
        .q   ({lmode, lmaster, lthr})
    );
    xmii_sync #(.W(2)) u_sts_sync (
        .clk (link_clk),
        .d   ({full_duplex, link_up}),
        .q   (ldup_link)
    );

    wire is_mii   = lmode == MODE_MII;
    wire is_rmii  = lmode == MODE_RMII;
    wire is_rgmii = lmode == MODE_RGMII;

    // ------------------------------------------------------------
    // Transmit capture (link clock rising edge)
    // ------------------------------------------------------------
    logic [NIB_W-1:0] txd_reg;
    logic             txen_reg;
    logic             txer_reg;
    logic [DIB_W-1:0] tx_dib_reg;
    logic             tx_half_reg;
    logic [NIB_W-1:0] tx_nib_next;
    logic             tx_nib_vld;

    always_ff @(posedge link_clk) begin
        txd_reg  <= tx_d;
        txen_reg <= tx_en;
        txer_reg <= tx_er;
    end

    // RMII dibit pairing into nibbles, TX_EN alone qualifies
    always_ff @(posedge link_clk) begin
        if (link_rst || !txen_reg) begin
            tx_half_reg <= 1'b0;
            tx_dib_reg  <= '0;
        end else begin
            tx_half_reg <= !tx_half_reg;
            tx_dib_reg  <= txd_reg[DIB_W-1:0];
        end
    end
    assign tx_nib_next = {txd_reg[DIB_W-1:0], tx_dib_reg};
    assign tx_nib_vld  = is_rmii ? (txen_reg && tx_half_reg) : txen_reg;

    // Nibble handshake toward core domain
    logic [NIB_W-1:0] xnib_reg;
    logic             xerr_reg;
    logic             xtog_reg;
    logic             xtog_s;
    logic             xtog_d_reg;
    logic [NIB_W-1:0] xnib_s;
    logic             xerr_s;

    // TX error propagation; reserved codes ignored
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            xtog_reg <= 1'b0;
            xnib_reg <= '0;
            xerr_reg <= 1'b0;
        end else if (tx_nib_vld) begin
            xtog_reg <= !xtog_reg;
            xnib_reg <= is_rmii ? tx_nib_next : txd_reg;
            xerr_reg <= txer_reg && !is_rmii;
        end
    end

    xmii_sync #(.W(NIB_W+2)) u_tx_sync (
        .clk (ref_clk),
        .d   ({xtog_reg, xerr_reg, xnib_reg}),
        .q   ({xtog_s, xerr_s, xnib_s})
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            xtog_d_reg    <= 1'b0;
            core_tx_valid <= 1'b0;
            core_tx_nib   <= '0;
            core_tx_err   <= 1'b0;
        end else begin
            xtog_d_reg    <= xtog_s;
            core_tx_valid <= xtog_s ^ xtog_d_reg;
            core_tx_nib   <= xnib_s;
            core_tx_err   <= xerr_s;
        end
    end

    // ------------------------------------------------------------
    // RMII receive elastic buffer (two serial lanes)
    // ------------------------------------------------------------
    logic [1:0] eb_bit;
    logic [1:0] eb_rdy;
    logic       eb_rd;
    logic       eb_run_reg;
    logic             line_rx_valid_c;
    logic [NIB_W-1:0] line_nib_c;

    genvar g;
    generate
        for (g = 0; g < DIB_W; g++) begin : g_lane
            xmii_elastic #(.DEPTH(DEPTH)) u_eb (
                .wr_clk   (ref_clk),
                .wr_rst   (rst),
                .wr_en    (line_rx_valid_c),
                .wr_bit   (line_nib_c[g]),
                .rd_clk   (link_clk),
                .rd_rst   (link_rst || !is_rmii),
                .thr      (lthr),
                .rd_en    (eb_rd),
                .rd_bit   (eb_bit[g]),
                .rd_ready (eb_rdy[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Line status into link domain (recovered stream on core clock)
    // ------------------------------------------------------------
    logic [2:0]       line_st_s;
    logic [NIB_W-1:0] line_nib_s;
    xmii_sync #(.W(1)) u_lv_sync (
        .clk (ref_clk),
        .d   (line_rx_valid),
        .q   (line_rx_valid_c)
    );
    xmii_sync #(.W(NIB_W)) u_ln_sync (
        .clk (ref_clk),
        .d   (line_rx_nib),
        .q   (line_nib_c)
    );
    xmii_sync #(.W(3)) u_ls_sync (
        .clk (link_clk),
        .d   ({line_rx_valid, line_rx_err, line_false_carrier}),
        .q   (line_st_s)
    );
    xmii_sync #(.W(NIB_W)) u_lns_sync (
        .clk (link_clk),
        .d   (line_rx_nib),
        .q   (line_nib_s)
    );

    wire lv  = line_st_s[2];
    wire ler = line_st_s[1];
    wire lfc = line_st_s[0];

    // Start draining only once threshold reached
    always_ff @(posedge link_clk) begin
        if (link_rst || !is_rmii) begin
            eb_run_reg <= 1'b0;
        end else if (&eb_rdy && lv) begin
            eb_run_reg <= 1'b1;
        end else if (!lv) begin
            eb_run_reg <= 1'b0;
        end
    end
    assign eb_rd = eb_run_reg;

    // ------------------------------------------------------------
    // Receive output encode
    // ------------------------------------------------------------
    logic [NIB_W-1:0] rxd_next;
    logic             dv_next;
    logic             er_next;
    logic             cr_next;
    logic             cf_next;
    wire  [NIB_W-1:0] inband = {ldup_link[1], SPEED_25M, ldup_link[0]};

    always_comb begin
        rxd_next = IDLE_NIBBLE;
        dv_next  = 1'b0;
        er_next  = 1'b0;
        cr_next  = 1'b0;
        cf_next  = 1'b0;
        unique case (lmode)
            MODE_MII: begin
                dv_next  = lv;
                er_next  = lv ? ler : lfc;
                rxd_next = lv ? line_nib_s : (lfc ? FALSE_CARRIER : IDLE_NIBBLE);
            end
            MODE_RMII: begin
                dv_next  = eb_run_reg;
                cr_next  = eb_run_reg;
                er_next  = eb_run_reg && ler;
                rxd_next = eb_run_reg ? {2'b00, eb_bit} : IDLE_NIBBLE;
            end
            MODE_RGMII: begin
                cr_next  = lv;
                cf_next  = lv ? ler : lfc;
                rxd_next = lv ? line_nib_s : (lfc ? FALSE_CARRIER : inband);
            end
            default: begin
                rxd_next = IDLE_NIBBLE;
            end
        endcase
    end

    // Launch on rising link edge, fall copy
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            rx_d         <= '0;
            rx_d_fall    <= '0;
            rx_dv        <= 1'b0;
            rx_er        <= 1'b0;
            crs_dv       <= 1'b0;
            rx_ctrl_rise <= 1'b0;
            rx_ctrl_fall <= 1'b0;
        end else begin
            rx_d         <= rxd_next;
            rx_d_fall    <= rxd_next;
            rx_dv        <= dv_next && !is_rgmii;
            rx_er        <= er_next && !is_rgmii;
            crs_dv       <= cr_next && is_rmii;
            rx_ctrl_rise <= cr_next && is_rgmii;
            rx_ctrl_fall <= cf_next && is_rgmii;
        end
    end

    // Reference out on RX_D3 in RMII master
    logic [2:0] ref_cnt_reg;
    wire  [2:0] ref_cnt_next = (ref_cnt_reg == REF_DIV_LAST) ? 3'h0 : ref_cnt_reg + 3'h1;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ref_cnt_reg <= 3'h0;
            ref_out     <= 1'b0;
            ref_out_oe  <= 1'b0;
        end else begin
            ref_cnt_reg <= ref_cnt_next;
            ref_out     <= (ref_cnt_reg < REF_HIGH) && mode_reg == MODE_RMII && master_reg;
            ref_out_oe  <= mode_reg == MODE_RMII && master_reg;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_fc_idle;
        is_mii && !lv && lfc;
    endsequence
    wire chk_hold = rst || link_rst;

    mii_false_carrier_a: assert property (@(posedge link_clk) disable iff (chk_hold)
        s_fc_idle |=> (rx_er && rx_d == FALSE_CARRIER))
        else $error("false carrier not flagged");
    rmii_crs_idle_a: assert property (@(posedge link_clk) disable iff (chk_hold)
        (is_rmii && !eb_run_reg) |=> !crs_dv && rx_d == IDLE_NIBBLE)
        else $error("rmii idle wrong");
    rmii_dv_match_a: assert property (@(posedge link_clk) disable iff (chk_hold)
        $past(is_rmii) |-> rx_dv == crs_dv)
        else $error("rmii valid mismatch");
    rgmii_inband_a: assert property (@(posedge link_clk) disable iff (chk_hold)
        (is_rgmii && !lv && !lfc) |=> rx_d[2:1] == SPEED_25M && !rx_ctrl_rise)
        else $error("inband status wrong");
    rgmii_ddr_copy_a: assert property (@(posedge link_clk) disable iff (chk_hold)
        rx_d_fall == rx_d)
        else $error("fall nibble differs");
    rgmii_fc_ctrl_a: assert property (@(posedge link_clk) disable iff (chk_hold)
        (is_rgmii && !lv && lfc) |=> !rx_ctrl_rise && rx_ctrl_fall && rx_d == FALSE_CARRIER)
        else $error("rgmii false carrier");
    unused_pins_a: assert property (@(posedge link_clk) disable iff (chk_hold)
        $past(is_mii) |-> !crs_dv && !rx_ctrl_rise && !rx_ctrl_fall)
        else $error("unused pin active");
    ref_out_oe_a: assert property (@(posedge ref_clk) disable iff (rst)
        ref_out |-> ref_out_oe)
        else $error("ref driven without enable");
endmodule : xmii_mac_if

// ---- inc/xmii_pkg.sv ----
// Constants and types shared by the MAC-side data interface
package xmii_pkg;
    // ------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_MII   = 2'b00,
        MODE_RMII  = 2'b01,
        MODE_RGMII = 2'b10
    } xmii_mode_e;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [3:0] FALSE_CARRIER = 4'hE;
    localparam logic [3:0] IDLE_NIBBLE   = 4'h0;
    localparam logic [1:0] SPEED_25M     = 2'h1;
    localparam int         NIB_W         = 4;
    localparam int         DIB_W         = 2;
    // Reference output divider: five core cycles per 50 MHz period
    localparam logic [2:0] REF_DIV_LAST  = 3'h4;
    localparam logic [2:0] REF_HIGH      = 3'h2;

    // ------------------------------------------------------------
    // Elastic buffer threshold limits (bits)
    // ------------------------------------------------------------
    localparam logic [2:0] THR_MIN     = 3'h2;
    localparam logic [2:0] THR_MAX     = 3'h5;
    localparam int         ELAST_DEPTH = 16;
    localparam int         PTR_W       = 4;
endpackage : xmii_pkg

// ---- rtl/xmii_sync.sv ----
// Two-stage level synchroniser, generic width
`timescale 1ns/100ps
module xmii_sync #(
    parameter int W = 1
) (
    // Clock
    input  wire logic         clk,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk) begin
        meta_reg <= d;
        q        <= meta_reg;
    end
endmodule : xmii_sync

// ---- rtl/xmii_elastic.sv ----
// Bit elastic buffer, recovered domain to reference domain
`timescale 1ns/100ps
module xmii_elastic
    import xmii_pkg::*;
#(
    parameter int DEPTH = ELAST_DEPTH
) (
    // Write side, recovered clock
    input  wire logic       wr_clk,
    input  wire logic       wr_rst,
    input  wire logic       wr_en,
    input  wire logic       wr_bit,
    // Read side, reference clock
    input  wire logic       rd_clk,
    input  wire logic       rd_rst,
    input  wire logic [2:0] thr,
    input  wire logic       rd_en,
    output logic            rd_bit,
    output logic            rd_ready
);
    // ------------------------------------------------------------
    // Storage, gray write pointer and binary read pointer
    // ------------------------------------------------------------
    logic [DEPTH-1:0] mem_reg;
    logic [PTR_W-1:0] wptr_reg;
    logic [PTR_W-1:0] wgray_reg;
    logic [PTR_W-1:0] wgray_s;
    logic [PTR_W-1:0] rptr_reg;
    logic [PTR_W-1:0] wbin;
    logic [PTR_W-1:0] fill;
    wire  [PTR_W-1:0] wptr_next = wptr_reg + 1'b1;

    always_ff @(posedge wr_clk) begin
        if (wr_rst) begin
            wptr_reg  <= '0;
            wgray_reg <= '0;
        end else if (wr_en) begin
            mem_reg[wptr_reg] <= wr_bit;
            wptr_reg  <= wptr_next;
            wgray_reg <= wptr_next ^ (wptr_next >> 1);
        end
    end

    xmii_sync #(.W(PTR_W)) u_wsync (
        .clk (rd_clk),
        .d   (wgray_reg),
        .q   (wgray_s)
    );

    // Gray to binary
    always_comb begin
        wbin[PTR_W-1] = wgray_s[PTR_W-1];
        for (int i = PTR_W-2; i >= 0; i--) begin
            wbin[i] = wbin[i+1] ^ wgray_s[i];
        end
    end

    assign fill     = wbin - rptr_reg;
    assign rd_ready = fill >= {1'b0, thr};
    assign rd_bit   = mem_reg[rptr_reg];

    always_ff @(posedge rd_clk) begin
        if (rd_rst) begin
            rptr_reg <= '0;
        end else if (rd_en && fill != '0) begin
            rptr_reg <= rptr_reg + 1'b1;
        end
    end
endmodule : xmii_elastic

// ---- tb/mac_model.sv ----
// MAC partner model: drives the transmit pins on the link clock
`timescale 1ns/100ps
module mac_model
    import xmii_pkg::*;
(
    // Link clock and mode
    input  wire logic       link_clk,
    input  wire logic [1:0] mode_sel,
    // Transmit pins
    output logic      [3:0] tx_d,
    output logic            tx_en,
    output logic            tx_er
);
    logic [4:0] q[$];
    logic       half;

    initial begin
        tx_d  = 4'h5;
        tx_en = 1'b0;
        tx_er = 1'b0;
        half  = 1'b0;
    end

    task automatic push(input logic [4:0] v);
        q.push_back(v);
    endtask : push

    always @(posedge link_clk) begin
        if (q.size() != 0 && mode_sel == MODE_RMII) begin
            tx_en <= 1'b1;
            tx_er <= q[0][4];
            tx_d  <= half ? {~tx_d[3:2], q[0][3:2]} : {~tx_d[3:2], q[0][1:0]};
            if (half) begin
                void'(q.pop_front());
            end
            half <= ~half;
        end else if (q.size() != 0) begin
            // en and er encode data or error
            tx_en <= 1'b1;
            tx_er <= q[0][4];
            tx_d  <= q[0][3:0];
            void'(q.pop_front());
        end else begin
            tx_en <= 1'b0;
            tx_er <= 1'b0;
            tx_d  <= ~tx_d;
        end
    end
endmodule : mac_model

// ---- tb/xmii_mac_if_tb_top.sv ----
// Self-checking bench of the MAC-side xMII data interface
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((ex) !== (gt)) begin errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module xmii_mac_if_tb_top;
    import xmii_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic       ref_clk, rst, rmii_master, full_duplex, link_up, link_clk;
    logic [1:0] mode_sel;
    logic [2:0] fifo_thr;
    logic       line_rx_valid, line_rx_err, line_false_carrier;
    logic [3:0] line_rx_nib, tx_d, rx_d, rx_d_fall, core_tx_nib, n;
    logic       tx_en, tx_er, rx_dv, rx_er, crs_dv, rx_ctrl_rise, rx_ctrl_fall;
    logic       ref_out, ref_out_oe, core_tx_valid, core_tx_err, prev;
    logic [4:0] exp_q[$];
    int         errors, cmp_count, i, k, cnt;

    // ------------------------------------------------------------
    // Clocks, design and partner
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        link_clk = 1'b0;
        #1.3;
        forever #6 link_clk = ~link_clk;
    end

    xmii_mac_if #(.DEPTH(ELAST_DEPTH)) xmii_mac_if_inst (
        .ref_clk(ref_clk), .rst(rst), .mode_sel(mode_sel), .rmii_master(rmii_master),
        .fifo_thr(fifo_thr), .full_duplex(full_duplex), .link_up(link_up),
        .link_clk(link_clk), .line_rx_valid(line_rx_valid), .line_rx_err(line_rx_err),
        .line_false_carrier(line_false_carrier), .line_rx_nib(line_rx_nib),
        .tx_d(tx_d), .tx_en(tx_en), .tx_er(tx_er), .rx_d(rx_d), .rx_d_fall(rx_d_fall),
        .rx_dv(rx_dv), .rx_er(rx_er), .crs_dv(crs_dv), .rx_ctrl_rise(rx_ctrl_rise),
        .rx_ctrl_fall(rx_ctrl_fall), .ref_out(ref_out), .ref_out_oe(ref_out_oe),
        .core_tx_nib(core_tx_nib), .core_tx_valid(core_tx_valid),
        .core_tx_err(core_tx_err)
    );

    mac_model mac_model_inst (
        .link_clk(link_clk), .mode_sel(mode_sel), .tx_d(tx_d), .tx_en(tx_en),
        .tx_er(tx_er)
    );

    // ------------------------------------------------------------
    // Transmit scoreboard
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (core_tx_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK("core_tx_extra", 1'b0, 1'b1)
            end else begin
                `CHK("core_tx", exp_q[0], {core_tx_err, core_tx_nib})
                void'(exp_q.pop_front());
            end
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic run_mode(input logic [1:0] m, input logic master);
        @(posedge ref_clk);
        rst         <= 1'b1;
        mode_sel    <= m;
        rmii_master <= master;
        fifo_thr    <= 3'($urandom_range(5, 2));
        full_duplex <= 1'($urandom);
        link_up     <= 1'($urandom);
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask : run_mode

    task automatic send(input logic [3:0] nib, input logic er);
        mac_model_inst.push({er, nib});
        exp_q.push_back({(mode_sel == MODE_RMII) ? 1'b0 : er, nib});
    endtask : send

    task automatic burst(input int cnt_n);
        for (k = 0; k < cnt_n; k++) begin
            send(4'($urandom_range(15, 0)), 1'($urandom));
        end
        for (k = 0; k < 3000 && exp_q.size() != 0; k++) begin
            @(posedge ref_clk);
        end
        if (exp_q.size() != 0) begin
            errors++;
            $display("CHECK FAILED tx_drain expected 0 seen %0d", exp_q.size());
            tally_and_finish();
        end
    endtask : burst

    task automatic line(input logic v, input logic e, input logic fc, input logic [3:0] d);
        @(posedge ref_clk);
        line_rx_valid      <= v;
        line_rx_err        <= e;
        line_false_carrier <= fc;
        line_rx_nib        <= d;
        repeat (24) @(posedge link_clk);
        @(negedge link_clk);
    endtask : line

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        errors = 0;
        cmp_count = 0;
        rst = 1'b1;
        mode_sel = MODE_MII;
        rmii_master = 1'b0;
        fifo_thr = THR_MIN;
        full_duplex = 1'b0;
        link_up = 1'b0;
        line_rx_valid = 1'b0;
        line_rx_err = 1'b0;
        line_false_carrier = 1'b0;
        line_rx_nib = 4'h0;
        void'($urandom(69158));
        // MII transmit, receive and false carrier
        run_mode(MODE_MII, 1'b0);
        `CHK("mii_ref_oe", 1'b0, ref_out_oe)
        burst(24);
        line(1'b0, 1'b0, 1'b1, 4'h3);
        `CHK("mii_fc", {1'b1, FALSE_CARRIER}, {rx_er, rx_d})
        line(1'b0, 1'b0, 1'b0, 4'h9);
        `CHK("mii_idle", 1'b0, rx_dv)
        n = 4'($urandom_range(15, 0));
        line(1'b1, 1'b0, 1'b0, n);
        `CHK("mii_data", {3'h4, n}, {rx_dv, rx_er, 1'b0, rx_d})
        line(1'b1, 1'b1, 1'b0, n);
        `CHK("mii_err", 2'h3, {rx_dv, rx_er})
        line(1'b0, 1'b0, 1'b0, 4'h0);
        // RMII slave then master
        for (i = 0; i < 2; i++) begin
            run_mode(MODE_RMII, 1'(i));
            `CHK("rmii_ref_oe", 1'(i), ref_out_oe)
            burst(20);
            line(1'b1, 1'b0, 1'b0, 4'($urandom_range(15, 0)));
            `CHK("rmii_valid", 2'h3, {crs_dv, rx_dv})
            line(1'b0, 1'b0, 1'b0, 4'h0);
            `CHK("rmii_idle", 2'h0, {crs_dv, rx_dv})
            if (i == 1) begin
                cnt = 0;
                prev = ref_out;
                @(posedge ref_clk);
                prev = ref_out;
                repeat (20) begin
                    @(posedge ref_clk);
                    if (ref_out !== prev) begin
                        cnt++;
                    end
                    prev = ref_out;
                end
                `CHK("rmii_ref_toggles", 8, cnt)
            end
        end
        // RGMII in-band status, receive control and transmit
        run_mode(MODE_RGMII, 1'b0);
        line(1'b0, 1'b0, 1'b0, 4'h0);
        `CHK("rgmii_status", {2'h0, full_duplex, SPEED_25M, link_up},
            {rx_ctrl_rise, rx_ctrl_fall, rx_d})
        n = 4'($urandom_range(15, 0));
        line(1'b1, 1'b0, 1'b0, n);
        `CHK("rgmii_data", {2'h2, n, n}, {rx_ctrl_rise, rx_ctrl_fall, rx_d, rx_d_fall})
        line(1'b1, 1'b1, 1'b0, n);
        `CHK("rgmii_err", 2'h3, {rx_ctrl_rise, rx_ctrl_fall})
        line(1'b0, 1'b0, 1'b1, 4'h0);
        `CHK("rgmii_fc", {2'h1, FALSE_CARRIER}, {rx_ctrl_rise, rx_ctrl_fall, rx_d})
        line(1'b0, 1'b0, 1'b0, 4'h0);
        for (k = 0; k < 12; k++) begin
            send(4'($urandom_range(15, 0)), 1'b0);
        end
        burst(0);
        `CHK("rgmii_ref_oe", 1'b0, ref_out_oe)
        tally_and_finish();
    end
endmodule : xmii_mac_if_tb_top
